// *** pkg/idpk_pkg.sv ***
// Package: register offsets, field layouts and constants of the identify data block
package idpk_pkg;

  // Register map, word offsets on the plain register port
  localparam logic [3:0] ADDR_COMMAND_OPCODE = 4'h0;
  localparam logic [3:0] ADDR_DRIVE_HEAD_SELECT = 4'h1;
  localparam logic [3:0] ADDR_TASK_STATE_FLAGS = 4'h2;
  localparam logic [3:0] ADDR_DATA_WORD = 4'h3;
  localparam logic [3:0] ADDR_ERROR_CODE = 4'h4;
  localparam logic [3:0] ADDR_CONTROL = 4'h5;
  localparam logic [3:0] ADDR_ERASE_TIME = 4'h6;
  localparam logic [3:0] ADDR_APM_LEVEL = 4'h7;
  localparam logic [3:0] ADDR_MASTER_REV = 4'h8;
  localparam logic [3:0] ADDR_SECURITY = 4'h9;
  localparam logic [3:0] ADDR_POWER_WORD = 4'hA;
  localparam logic [3:0] ADDR_RESET_RESULT = 4'hB;

  // Command opcode
  localparam logic [7:0] OPC_PACKET_IDENTIFY = 8'hA1;
  // Error register abort bit
  localparam int ERR_ABORT_BIT = 2;
  localparam logic [7:0] ERR_ABORT = 8'h04;

  // Status bit positions
  localparam int ST_BUSY = 7;
  localparam int ST_READY = 6;
  localparam int ST_FAULT = 5;
  localparam int ST_DREQ = 3;
  localparam int ST_ERR = 0;
  // Drive/head select bit
  localparam int DH_DEV = 4;

  // Identification word indices
  localparam logic [7:0] W_ERASE = 8'h59;
  localparam logic [7:0] W_ENH_ERASE = 8'h5A;
  localparam logic [7:0] W_APM = 8'h5B;
  localparam logic [7:0] W_MREV = 8'h5C;
  localparam logic [7:0] W_HWRESET = 8'h5D;
  localparam logic [7:0] W_MEDIA = 8'h7F;
  localparam logic [7:0] W_SECURITY = 8'h80;
  localparam logic [7:0] W_POWER = 8'hA0;
  localparam logic [7:0] W_INTEGRITY = 8'hFF;
  localparam logic [7:0] W_LAST = 8'hFF;

  // Word 127 value and integrity signature
  localparam logic [15:0] MEDIA_NOTIFY_WORD = 16'h0001;
  localparam logic [7:0] INTEGRITY_SIG = 8'hA5;
  // Erase code for more than 508 minutes
  localparam logic [7:0] ERASE_OVER_MAX = 8'hFF;

  // Security word field positions
  localparam int SEC_SUPPORTED = 0;
  localparam int SEC_ENABLED = 1;
  localparam int SEC_LOCKED = 2;
  localparam int SEC_FROZEN = 3;
  localparam int SEC_EXPIRED = 4;
  localparam int SEC_ENH = 5;
  localparam int SEC_MAXLVL = 8;

  // Reset values
  localparam logic [7:0] RST_DRIVE_HEAD = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h40;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // Preparation time before data is offered
  localparam int PREP_TIME_NS = 1000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int PREP_CYCLES = (PREP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    IDPK_IDLE = 2'b00,
    IDPK_PREP = 2'b01,
    IDPK_XFER = 2'b10
  } idpk_state_t;

  // Security settings written by software
  typedef struct packed {
    logic maxLevel;
    logic enhSupported;
    logic frozen;
    logic locked;
    logic enabled;
    logic supported;
  } idpk_sec_t;

  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } idpk_req_t;

endpackage : idpk_pkg

// *** rtl/idpk_identify.sv ***
// Device-side identify data engine with packet identify command handling
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/100ps

module idpk_identify #(
  parameter bit PACKET_FEATURE = 1'b1,
  parameter bit INTEGRITY_WORD = 1'b1,
  parameter bit DEVICE_NUMBER = 1'b0,
  parameter int PREP_COUNT = idpk_pkg::PREP_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  input wire logic cableDetect,
  input wire logic hwResetDone,
  input wire logic [7:0] hwResetOutcome,
  input wire logic unlockCountExpired,
  input wire logic interruptsDisabled,
  output logic intrq
);

  initial begin
    if (PREP_COUNT < 1 || PREP_COUNT > 65535) begin
      $error("PREP_COUNT out of range");
    end
  end

  localparam logic [15:0] PREP_LAST = 16'(PREP_COUNT - 1);

  // ==========================================================
  // Reset release
  logic [1:0] rstSync;
  logic rstN;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rstSync <= 2'b00;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstN = rstSync[1];

  // ==========================================================
  // Cable detect pin synchroniser
  logic [2:0] cableSync;
  logic cableLevel;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      cableSync <= 3'b000;
      cableLevel <= 1'b0;
    end else begin
      cableSync <= {cableSync[1:0], cableDetect};
      if (cableSync[1] == cableSync[2]) begin
        cableLevel <= cableSync[2];
      end
    end
  end

  // ==========================================================
  // Register port decode
  idpk_pkg::idpk_req_t req;
  assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

  logic cmdWrite;
  assign cmdWrite = req.wr && (req.addr == idpk_pkg::ADDR_COMMAND_OPCODE);

  // ==========================================================
  // Software-set identification fields
  logic [7:0] enhEraseTime;
  logic [7:0] apmLevel;
  logic [15:0] masterRev;
  idpk_pkg::idpk_sec_t sec;
  logic [15:0] powerWord;
  logic [7:0] driveHead;
  logic [7:0] errorCode;
  logic [15:0] hwResultWord;
  logic countExpired;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      enhEraseTime <= 8'h00;
      apmLevel <= 8'h00;
      masterRev <= idpk_pkg::RST_WORD;
      sec <= '0;
      powerWord <= idpk_pkg::RST_WORD;
      driveHead <= idpk_pkg::RST_DRIVE_HEAD;
    end else if (req.wr) begin
      unique case (req.addr)
        idpk_pkg::ADDR_ERASE_TIME: enhEraseTime <= req.wdata[7:0];
        idpk_pkg::ADDR_APM_LEVEL: apmLevel <= req.wdata[7:0];
        idpk_pkg::ADDR_MASTER_REV: masterRev <= req.wdata;
        idpk_pkg::ADDR_SECURITY: sec <= req.wdata[5:0];
        idpk_pkg::ADDR_POWER_WORD: powerWord <= {2'b00, req.wdata[13:0]};
        idpk_pkg::ADDR_DRIVE_HEAD_SELECT: driveHead <= req.wdata[7:0];
        default: begin
        end
      endcase
    end
  end

  // Expired flag holds until reset
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      countExpired <= 1'b0;
    end else if (unlockCountExpired) begin
      countExpired <= 1'b1;
    end
  end

  // Hardware reset result placement by device number
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      hwResultWord <= idpk_pkg::RST_WORD;
    end else if (hwResetDone) begin
      if (DEVICE_NUMBER == 1'b0) begin
        hwResultWord <= {8'h00, hwResetOutcome};
      end else begin
        hwResultWord <= {2'b00, hwResetOutcome[5:0], 8'h00};
      end
    end
  end

  // ==========================================================
  // Identification word source
  function automatic logic [15:0] idWord(input logic [7:0] idx, input logic [7:0] sum);
    logic [15:0] w;
    w = 16'h0000;
    unique case (idx)
      idpk_pkg::W_ENH_ERASE: w = {8'h00, enhEraseTime};
      idpk_pkg::W_APM: w = {8'h00, apmLevel};
      idpk_pkg::W_MREV: w = masterRev;
      idpk_pkg::W_HWRESET: w = {hwResultWord[15:14], cableLevel, hwResultWord[12:0]};
      idpk_pkg::W_MEDIA: w = idpk_pkg::MEDIA_NOTIFY_WORD;
      idpk_pkg::W_SECURITY: begin
        w[idpk_pkg::SEC_MAXLVL] = sec.enabled & sec.maxLevel;
        w[idpk_pkg::SEC_ENH] = sec.enhSupported;
        w[idpk_pkg::SEC_EXPIRED] = countExpired;
        w[idpk_pkg::SEC_FROZEN] = sec.frozen;
        w[idpk_pkg::SEC_LOCKED] = sec.locked;
        w[idpk_pkg::SEC_ENABLED] = sec.enabled;
        w[idpk_pkg::SEC_SUPPORTED] = sec.supported;
      end
      idpk_pkg::W_POWER: w = powerWord;
      idpk_pkg::W_INTEGRITY: begin
        if (INTEGRITY_WORD) begin
          w = {8'(-(sum + idpk_pkg::INTEGRITY_SIG)), idpk_pkg::INTEGRITY_SIG};
        end
      end
      default: w = 16'h0000;
    endcase
    return w;
  endfunction

  // ==========================================================
  // Command engine
  idpk_pkg::idpk_state_t state;
  logic [15:0] prepCount;
  logic [7:0] wordIdx;
  logic [7:0] byteSum;
  logic [7:0] next_sum;
  logic busy;
  logic dreq;
  logic errBit;
  logic deviceSelected;
  logic isIdentify;
  logic dataRead;
  logic [15:0] curWord;

  assign deviceSelected = (driveHead[idpk_pkg::DH_DEV] == DEVICE_NUMBER);
  assign isIdentify = PACKET_FEATURE && (req.wdata[7:0] == idpk_pkg::OPC_PACKET_IDENTIFY);
  assign dataRead = req.rd && (req.addr == idpk_pkg::ADDR_DATA_WORD)
    && (state == idpk_pkg::IDPK_XFER);

  // Word source also reads the field registers, so it must follow them
  always_comb begin
    curWord = idWord(wordIdx, byteSum);
  end

  // Running byte sum of the words already handed out plus the word now offered
  assign next_sum = byteSum + curWord[15:8] + curWord[7:0];

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      state <= idpk_pkg::IDPK_IDLE;
      prepCount <= 16'h0000;
      wordIdx <= 8'h00;
      byteSum <= 8'h00;
      busy <= 1'b0;
      dreq <= 1'b0;
      errBit <= 1'b0;
      errorCode <= 8'h00;
      intrq <= 1'b0;
    end else begin
      if (req.rd && req.addr == idpk_pkg::ADDR_TASK_STATE_FLAGS) begin
        intrq <= 1'b0;
      end
      unique case (state)
        idpk_pkg::IDPK_IDLE: begin
          // Accepted regardless of ready
          if (cmdWrite && deviceSelected) begin
            if (isIdentify) begin
              state <= idpk_pkg::IDPK_PREP;
              busy <= 1'b1;
              dreq <= 1'b0;
              errBit <= 1'b0;
              errorCode <= 8'h00;
              prepCount <= 16'h0000;
              wordIdx <= 8'h00;
              byteSum <= 8'h00;
              intrq <= 1'b0;
            end else begin
              errBit <= 1'b1;
              errorCode <= idpk_pkg::ERR_ABORT;
              intrq <= !interruptsDisabled;
            end
          end
        end
        idpk_pkg::IDPK_PREP: begin
          if (prepCount == PREP_LAST) begin
            state <= idpk_pkg::IDPK_XFER;
            busy <= 1'b0;
            dreq <= 1'b1;
            intrq <= !interruptsDisabled;
          end else begin
            prepCount <= prepCount + 16'h0001;
          end
        end
        idpk_pkg::IDPK_XFER: begin
          if (dataRead) begin
            byteSum <= next_sum;
            if (wordIdx == idpk_pkg::W_LAST) begin
              state <= idpk_pkg::IDPK_IDLE;
              dreq <= 1'b0;
              busy <= 1'b0;
              errBit <= 1'b0;
            end else begin
              wordIdx <= wordIdx + 8'h01;
            end
          end
        end
        default: state <= idpk_pkg::IDPK_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Read data
  logic [7:0] statusByte;
  always_comb begin
    statusByte = 8'h00;
    statusByte[idpk_pkg::ST_BUSY] = busy;
    statusByte[idpk_pkg::ST_READY] = 1'b1;
    statusByte[idpk_pkg::ST_FAULT] = 1'b0;
    statusByte[idpk_pkg::ST_DREQ] = dreq;
    statusByte[idpk_pkg::ST_ERR] = errBit;
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      regRdata <= 16'h0000;
    end else if (req.rd) begin
      unique case (req.addr)
        idpk_pkg::ADDR_DRIVE_HEAD_SELECT: regRdata <= {8'h00, driveHead};
        idpk_pkg::ADDR_TASK_STATE_FLAGS: regRdata <= {8'h00, statusByte};
        idpk_pkg::ADDR_DATA_WORD: regRdata <= (state == idpk_pkg::IDPK_XFER) ? curWord : 16'h0000;
        idpk_pkg::ADDR_ERROR_CODE: regRdata <= {8'h00, errorCode};
        idpk_pkg::ADDR_ERASE_TIME: regRdata <= {8'h00, enhEraseTime};
        idpk_pkg::ADDR_APM_LEVEL: regRdata <= {8'h00, apmLevel};
        idpk_pkg::ADDR_MASTER_REV: regRdata <= masterRev;
        idpk_pkg::ADDR_SECURITY: regRdata <= {10'h000, sec};
        idpk_pkg::ADDR_POWER_WORD: regRdata <= powerWord;
        idpk_pkg::ADDR_RESET_RESULT: regRdata <= hwResultWord;
        idpk_pkg::ADDR_CONTROL: regRdata <= {15'h0000, countExpired};
        default: regRdata <= 16'h0000;
      endcase
    end else begin
      regRdata <= 16'h0000;
    end
  end

endmodule : idpk_identify

// *** bench/idpk_host_env.sv ***
// Far-side model: reset-outcome strobe and cable-detect level
`timescale 1ns/100ps
module idpk_host_env #(
  parameter bit CABLE_HIGH = 1'b1
) (
  input wire logic clk,
  input wire logic fire,
  input wire logic [7:0] outcome,
  output logic cableDetect,
  output logic hwResetDone,
  output logic [7:0] hwResetOutcome
);
  // ==========================================
  // Cable level held steady through commands
  assign cableDetect = CABLE_HIGH;
  initial begin
    hwResetDone = 1'b0;
    hwResetOutcome = 8'h00;
  end
  // One-cycle outcome strobe; value scrambled when not strobed
  always @(posedge clk) begin
    hwResetDone <= fire;
    hwResetOutcome <= fire ? outcome : ~hwResetOutcome;
  end
endmodule : idpk_host_env

// *** bench/idpk_identify_assertions.sv ***
// Port checks of the identify engine
`timescale 1ns/100ps
module idpk_identify_assertions #(
  parameter bit DEVICE_NUMBER = 1'b0,
  parameter int PREP_COUNT = idpk_pkg::PREP_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [15:0] regRdata,
  input wire logic interruptsDisabled,
  input wire logic intrq
);
  // Command edge plus preparation plus the register stage of intrq
  localparam int IRQ_LAST = PREP_COUNT + 2;
  logic devSel;
  logic cmdId;
  assign cmdId = regWr && regAddr == idpk_pkg::ADDR_COMMAND_OPCODE
    && regWdata[7:0] == idpk_pkg::OPC_PACKET_IDENTIFY && devSel == DEVICE_NUMBER
    && !interruptsDisabled;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      devSel <= 1'b0;
    end else if (regWr && regAddr == idpk_pkg::ADDR_DRIVE_HEAD_SELECT) begin
      devSel <= regWdata[idpk_pkg::DH_DEV];
    end
  end
  // ==========================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence stat_rd;
    regRd && regAddr == idpk_pkg::ADDR_TASK_STATE_FLAGS;
  endsequence
  rd_idle_a: assert property (!$past(regRd) |-> regRdata == 16'h0000)
    else $error("read data outside read slot");
  ready_on_a: assert property (stat_rd |=> regRdata[idpk_pkg::ST_READY])
    else $error("ready bit low");
  no_fault_a: assert property (stat_rd |=> !regRdata[idpk_pkg::ST_FAULT])
    else $error("fault bit set");
  busy_dreq_a: assert property (stat_rd |=> !(regRdata[7] && regRdata[3]))
    else $error("busy with data request");
  irq_off_a: assert property (interruptsDisabled && $past(interruptsDisabled) |-> !intrq)
    else $error("interrupt while disabled");
  cmd_intr_a: assert property (cmdId |-> ##[1:IRQ_LAST] intrq)
    else $error("no interrupt after identify");
  stat_clr_a: assert property (stat_rd |-> ##[1:2] !intrq)
    else $error("interrupt kept after status read");
  irq_dev_a: assert property ($rose(intrq) |-> devSel == DEVICE_NUMBER)
    else $error("other device answered");
  cover property (stat_rd ##1 regRdata[idpk_pkg::ST_DREQ]);
  cover property ($rose(intrq));
  cover property (regRd && regAddr == idpk_pkg::ADDR_DATA_WORD);
endmodule : idpk_identify_assertions

bind idpk_identify idpk_identify_assertions #(.DEVICE_NUMBER(DEVICE_NUMBER),
  .PREP_COUNT(PREP_COUNT)) u_chk (
  .clk(clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
  .regRd(regRd), .regRdata(regRdata), .interruptsDisabled(interruptsDisabled), .intrq(intrq));

// *** bench/idpk_identify_bench.sv ***
// Testbench of the identify engine
`timescale 1ns/100ps
module idpk_identify_bench;
  logic clk = 1'b0;
  logic nrst, regWr, regRd, cableDetect, hwResetDone, fire, unlockCountExpired;
  logic interruptsDisabled, intrq;
  logic [3:0] regAddr;
  logic [15:0] regWdata, regRdata, d;
  logic [7:0] hwResetOutcome;
  logic [15:0] w [256];
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  always #12.5 clk = ~clk;
  idpk_identify #(.DEVICE_NUMBER(1'b0), .PREP_COUNT(2)) u_idpk_identify (
    .clk(clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .cableDetect(cableDetect),
    .hwResetDone(hwResetDone), .hwResetOutcome(hwResetOutcome),
    .unlockCountExpired(unlockCountExpired), .interruptsDisabled(interruptsDisabled),
    .intrq(intrq));
  idpk_host_env u_idpk_host_env (.clk(clk), .fire(fire), .outcome(8'h3B),
    .cableDetect(cableDetect), .hwResetDone(hwResetDone), .hwResetOutcome(hwResetOutcome));
  // ==========================================
  // Bus and check tasks
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    v = regRdata;
  endtask : rd
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_irq;
    for (int i = 0; i < 100 && intrq !== 1'b1; i++) @(posedge clk);
  endtask : wait_irq
  task automatic read_block;
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 256; i++) begin
      rd(idpk_pkg::ADDR_DATA_WORD, w[i]);
      s = s + w[i][7:0] + w[i][15:8];
    end
    chk({8'h00, s}, 16'h0000);
  endtask : read_block
  task automatic end_of_test;
    $display("Mismatches %0d, comparisons %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test;
    end
  end
  // ==========================================
  // Scenarios
  initial begin
    nrst = 1'b0;
    regAddr = 4'h0;
    regWdata = 16'h0000;
    regWr = 1'b0;
    regRd = 1'b0;
    fire = 1'b0;
    unlockCountExpired = 1'b0;
    interruptsDisabled = 1'b0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    rd(idpk_pkg::ADDR_TASK_STATE_FLAGS, d);
    chk(d, 16'h0040);
    wr(idpk_pkg::ADDR_ERASE_TIME, 16'h00FF);
    wr(idpk_pkg::ADDR_APM_LEVEL, 16'h0080);
    wr(idpk_pkg::ADDR_MASTER_REV, 16'h1234);
    wr(idpk_pkg::ADDR_POWER_WORD, 16'h2064);
    wr(idpk_pkg::ADDR_SECURITY, 16'h0023);
    wr(idpk_pkg::ADDR_DRIVE_HEAD_SELECT, 16'h00A0);
    @(posedge clk);
    fire <= 1'b1;
    unlockCountExpired <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    unlockCountExpired <= 1'b0;
    wr(idpk_pkg::ADDR_COMMAND_OPCODE, 16'h00A1);
    wait_irq;
    chk({15'h0000, intrq}, 16'h0001);
    rd(idpk_pkg::ADDR_TASK_STATE_FLAGS, d);
    chk(d, 16'h0048);
    read_block;
    chk(w[90], 16'h00FF);
    chk(w[91], 16'h0080);
    chk(w[92], 16'h1234);
    chk(w[93], 16'h203B);
    chk(w[127], 16'h0001);
    chk(w[128], 16'h0113);
    chk(w[160], 16'h2064);
    chk({8'h00, w[255][7:0]}, 16'h00A5);
    rd(idpk_pkg::ADDR_TASK_STATE_FLAGS, d);
    chk(d, 16'h0040);
    rd(idpk_pkg::ADDR_DRIVE_HEAD_SELECT, d);
    chk(d, 16'h00A0);
    // Other device selected: command ignored
    wr(idpk_pkg::ADDR_DRIVE_HEAD_SELECT, 16'h00B0);
    wr(idpk_pkg::ADDR_COMMAND_OPCODE, 16'h00A1);
    repeat (10) @(posedge clk);
    chk({15'h0000, intrq}, 16'h0000);
    rd(idpk_pkg::ADDR_TASK_STATE_FLAGS, d);
    chk(d, 16'h0040);
    // Interrupts off: data still offered
    @(posedge clk);
    interruptsDisabled <= 1'b1;
    wr(idpk_pkg::ADDR_DRIVE_HEAD_SELECT, 16'h00A0);
    wr(idpk_pkg::ADDR_COMMAND_OPCODE, 16'h00A1);
    repeat (8) @(posedge clk);
    chk({15'h0000, intrq}, 16'h0000);
    rd(idpk_pkg::ADDR_TASK_STATE_FLAGS, d);
    chk(d, 16'h0048);
    read_block;
    @(posedge clk);
    interruptsDisabled <= 1'b0;
    // Unknown opcode aborts
    wr(idpk_pkg::ADDR_COMMAND_OPCODE, 16'h00EC);
    wait_irq;
    chk({15'h0000, intrq}, 16'h0001);
    rd(idpk_pkg::ADDR_TASK_STATE_FLAGS, d);
    chk(d, 16'h0041);
    rd(idpk_pkg::ADDR_ERROR_CODE, d);
    chk(d, 16'h0004);
    end_of_test;
  end
endmodule : idpk_identify_bench
